// *** pexc_defs.svh ***
// constants of the exception entry and return unit
// assumes a 32-bit core with a fetch pc one word per instruction
`ifndef PEXC_DEFS_SVH
`define PEXC_DEFS_SVH

// ====================================================
// vector table
`define PEXC_VEC_RESET   32'h0000_0000
`define PEXC_VEC_UNDEF   32'h0000_0004
`define PEXC_VEC_SWI     32'h0000_0008
`define PEXC_VEC_PABT    32'h0000_000C
`define PEXC_VEC_DABT    32'h0000_0010
`define PEXC_VEC_RSVD    32'h0000_0014
`define PEXC_VEC_IRQ     32'h0000_0018
`define PEXC_VEC_FIQ     32'h0000_001C
`define PEXC_VEC_BYTES   32'h0000_0020

// ====================================================
// status word fields and mode codes
`define PEXC_SW_MODE_LSB 0
`define PEXC_SW_MODE_MSB 4
`define PEXC_SW_F        6
`define PEXC_SW_I        7
`define PEXC_MODE_USR    5'h00
`define PEXC_MODE_FIQ    5'h01
`define PEXC_MODE_IRQ    5'h02
`define PEXC_MODE_SVC    5'h03
`define PEXC_MODE_ABT    5'h04
`define PEXC_MODE_UND    5'h05
`define PEXC_SW_RESET    32'h0000_00C0
`define PEXC_LINK_OFS    32'h0000_0004

// ====================================================
// register byte offsets
`define PEXC_REG_STATUS  5'h00
`define PEXC_REG_SAVED   5'h04
`define PEXC_REG_LINK    5'h08
`define PEXC_REG_STACK   5'h0C
`define PEXC_REG_STATE   5'h10
`define PEXC_REG_LASTVEC 5'h14

`endif

// *** pexc_mmu_model.sv ***
// far side model: memory management abort pulses and interrupt pins
// assumes the bench calls its tasks from the clk_sys domain
`timescale 1ns/1ps
`default_nettype none

module pexc_mmu_model (
  // clock
  input  wire logic clk_sys,
  // abort pulses and active-low request pins
  output logic      pabt_req,
  output logic      dabt_req,
  output logic      irq_n_pin,
  output logic      fiq_n_pin
);
  initial begin
    pabt_req  = 1'b0;
    dabt_req  = 1'b0;
    irq_n_pin = 1'b1;
    fiq_n_pin = 1'b1;
  end

  // ====================================================
  // one-cycle abort pulses, both in one cycle if asked
  task automatic raise(input logic d, input logic p);
    @(posedge clk_sys);
    dabt_req <= d;
    pabt_req <= p;
    @(posedge clk_sys);
    dabt_req <= 1'b0;
    pabt_req <= 1'b0;
  endtask

  // pins are levels, held until the bench lets go
  task automatic pins(input logic irq_low, input logic fiq_low);
    @(posedge clk_sys);
    irq_n_pin <= ~irq_low;
    fiq_n_pin <= ~fiq_low;
  endtask
endmodule

`default_nettype wire

// *** pexc_pkg.sv ***
// types of the exception entry and return unit
// assumes pexc_defs.svh is on the include path
package pexc_pkg;

  // ====================================================
  // sequencer states and exception causes
  typedef enum logic [1:0] {PEXC_ST_IDLE, PEXC_ST_ENTRY, PEXC_ST_VECTOR} pexc_state_e;

  typedef enum logic [2:0] {
    PEXC_C_NONE, PEXC_C_RESET, PEXC_C_DABT, PEXC_C_FIQ,
    PEXC_C_IRQ, PEXC_C_PABT, PEXC_C_UNDEF, PEXC_C_SWI
  } pexc_cause_e;

  // bank index: 0 user, 1 fiq, 2 irq, 3 svc, 4 abort, 5 illegal opcode
  typedef logic [2:0] pexc_bank_t;

endpackage

// *** pexc_unit.sv ***
// exception entry and return sequencer with banked status, link and stack registers
// assumes a core that pulses cause requests and instruction completion on clk_sys,
// and an avalon-mm master with waitrequest for the register window
`timescale 1ns/1ps
`default_nettype none
`include "pexc_defs.svh"

module pexc_unit (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset,
  // avalon-mm register slave
  input  wire logic [4:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // interrupt pins, active low, asynchronous
  input  wire logic              irq_n_pin,
  input  wire logic              fiq_n_pin,
  // core events
  input  wire logic              instr_done,
  input  wire logic              undef_req,
  input  wire logic              swi_req,
  input  wire logic              pabt_req,
  input  wire logic              dabt_req,
  input  wire logic [31:0]       fetch_pc,
  // return requests
  input  wire logic              ret_dp_req,
  input  wire logic              ret_ldm_req,
  input  wire logic [31:0]       ret_pc,
  output logic                   ret_ack,
  // program counter load and state
  output logic                   pc_load,
  output logic [31:0]            pc_load_addr,
  output logic [31:0]            cur_status_word,
  output pexc_pkg::pexc_bank_t   bank_sel,
  output logic                   fiq_bank_sel,
  output logic                   entry_busy
);
  import pexc_pkg::*;

  // ====================================================
  // decoding functions
  function automatic pexc_bank_t mode_bank(input logic [4:0] m);
    mode_bank = (m <= `PEXC_MODE_UND) ? m[2:0] : 3'h0;
  endfunction

  function automatic logic [4:0] cause_mode(input pexc_cause_e c);
    case (c)
      PEXC_C_FIQ:   cause_mode = `PEXC_MODE_FIQ;
      PEXC_C_IRQ:   cause_mode = `PEXC_MODE_IRQ;
      PEXC_C_DABT,
      PEXC_C_PABT:  cause_mode = `PEXC_MODE_ABT;
      PEXC_C_UNDEF: cause_mode = `PEXC_MODE_UND;
      default:      cause_mode = `PEXC_MODE_SVC;
    endcase
  endfunction

  // reserved word 0x14 is never produced
  function automatic logic [31:0] cause_vec(input pexc_cause_e c);
    case (c)
      PEXC_C_UNDEF: cause_vec = `PEXC_VEC_UNDEF;
      PEXC_C_SWI:   cause_vec = `PEXC_VEC_SWI;
      PEXC_C_PABT:  cause_vec = `PEXC_VEC_PABT;
      PEXC_C_DABT:  cause_vec = `PEXC_VEC_DABT;
      PEXC_C_IRQ:   cause_vec = `PEXC_VEC_IRQ;
      PEXC_C_FIQ:   cause_vec = `PEXC_VEC_FIQ;
      default:      cause_vec = `PEXC_VEC_RESET;
    endcase
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      be_merge[8*b +: 8] = be[b] ? n[8*b +: 8] : o[8*b +: 8];
    end
  endfunction

  // ====================================================
  // state
  pexc_state_e  state_q;
  pexc_cause_e  cause_q;
  pexc_cause_e  win;
  pexc_bank_t   hidx_q;
  pexc_bank_t   cur_idx;
  logic [31:0]  status_q;
  logic [31:0]  status_d;
  logic [31:0]  saved_q [0:5];
  logic [31:0]  lr_q [0:5];
  logic [31:0]  sp_q [0:5];
  logic [31:0]  ent_pc_q;
  logic [31:0]  lastvec_q;
  logic [31:0]  rd_mux;
  logic [31:0]  cur_saved;
  logic [3:0]   pend_q;
  logic [3:0]   pend_set;
  logic [3:0]   pend_clr;
  logic         reset_p_q;
  logic         after_q;
  logic         irq_meta_q;
  logic         irq_s_q;
  logic         fiq_meta_q;
  logic         fiq_s_q;
  logic         ack_q;
  logic         pc_load_q;
  logic [31:0]  pc_addr_q;
  logic [31:0]  rdata_q;

  // ====================================================
  // pin synchronisers, second stage only is read
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_meta_q <= 1'b1;
      irq_s_q    <= 1'b1;
      fiq_meta_q <= 1'b1;
      fiq_s_q    <= 1'b1;
    end else begin
      irq_meta_q <= irq_n_pin;
      irq_s_q    <= irq_meta_q;
      fiq_meta_q <= fiq_n_pin;
      fiq_s_q    <= fiq_meta_q;
    end
  end

  // ====================================================
  // pending causes {swi, undef, pabt, dabt}; set wins over clear
  wire idle     = (state_q == PEXC_ST_IDLE);
  wire priv     = (cur_idx != 3'h0);
  wire int_win  = instr_done | after_q;
  wire fiq_act  = ~fiq_s_q & ~status_q[`PEXC_SW_F] & int_win;
  wire irq_act  = ~irq_s_q & ~status_q[`PEXC_SW_I] & int_win;
  wire ret_any  = ret_dp_req | ret_ldm_req;
  wire take     = idle & (win != PEXC_C_NONE);

  assign cur_idx   = mode_bank(status_q[`PEXC_SW_MODE_MSB:`PEXC_SW_MODE_LSB]);
  assign cur_saved = saved_q[cur_idx];
  // a trap decoding is dropped if the same slot also flags illegal opcode
  assign pend_set  = {swi_req & ~undef_req, undef_req, pabt_req, dabt_req};
  assign pend_clr  = {4{idle}} & {win == PEXC_C_SWI, win == PEXC_C_UNDEF,
                                  win == PEXC_C_PABT, win == PEXC_C_DABT};

  // fixed priority: reset, data abort, fiq, irq, prefetch abort, undef/swi
  assign win = reset_p_q ? PEXC_C_RESET :
               pend_q[0] ? PEXC_C_DABT  :
               fiq_act   ? PEXC_C_FIQ   :
               irq_act   ? PEXC_C_IRQ   :
               pend_q[1] ? PEXC_C_PABT  :
               pend_q[2] ? PEXC_C_UNDEF :
               pend_q[3] ? PEXC_C_SWI   : PEXC_C_NONE;

  // ====================================================
  // bus and return handshakes; both wait for an idle, quiet sequencer
  wire bus_req  = avs_read | avs_write;
  wire bus_acc  = bus_req & idle & ~take & ~ret_any & ~ack_q;
  wire wr_go    = avs_write & ack_q;
  wire ret_go   = idle & ~take & ret_any & ~ack_q;
  wire wr_stat  = wr_go & (avs_address == `PEXC_REG_STATUS);
  wire wr_saved = wr_go & (avs_address == `PEXC_REG_SAVED) & priv;
  wire wr_link  = wr_go & (avs_address == `PEXC_REG_LINK);
  wire wr_stack = wr_go & (avs_address == `PEXC_REG_STACK);

  assign avs_waitrequest = bus_req & ~ack_q;
  assign ret_ack         = ret_go;

  assign rd_mux = (avs_address == `PEXC_REG_STATUS)  ? status_q :
                  (avs_address == `PEXC_REG_SAVED)   ? (priv ? cur_saved : 32'h0000_0000) :
                  (avs_address == `PEXC_REG_LINK)    ? lr_q[cur_idx] :
                  (avs_address == `PEXC_REG_STACK)   ? sp_q[cur_idx] :
                  (avs_address == `PEXC_REG_STATE)   ? {23'h00_0000, state_q, reset_p_q,
                                                         ~fiq_s_q, ~irq_s_q, pend_q} :
                  (avs_address == `PEXC_REG_LASTVEC) ? lastvec_q : 32'h0000_0000;

  // ====================================================
  // next status word
  always_comb begin
    status_d = status_q;
    if (state_q == PEXC_ST_ENTRY) begin
      status_d[`PEXC_SW_MODE_MSB:`PEXC_SW_MODE_LSB] = cause_mode(cause_q);
      status_d[`PEXC_SW_I] = 1'b1;
      if (cause_q == PEXC_C_FIQ) begin
        status_d[`PEXC_SW_F] = 1'b1;
      end
    end else if (ret_go & priv) begin
      status_d = cur_saved;
    end else if (wr_stat) begin
      status_d = be_merge(status_q, avs_writedata, avs_byteenable);
    end
  end

  // ====================================================
  // sequencer: idle arbitrates, entry saves, vector loads the pc
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q   <= PEXC_ST_IDLE;
      cause_q   <= PEXC_C_NONE;
      hidx_q    <= 3'h0;
      ent_pc_q  <= 32'h0000_0000;
      reset_p_q <= 1'b1;
      after_q   <= 1'b0;
      pend_q    <= 4'h0;
    end else begin
      pend_q  <= (pend_q & ~pend_clr) | pend_set;
      after_q <= (state_q == PEXC_ST_VECTOR);
      case (state_q)
        PEXC_ST_IDLE: begin
          if (take) begin
            state_q   <= PEXC_ST_ENTRY;
            cause_q   <= win;
            hidx_q    <= mode_bank(cause_mode(win));
            ent_pc_q  <= fetch_pc;
            reset_p_q <= 1'b0;
          end
        end
        PEXC_ST_ENTRY:  state_q <= PEXC_ST_VECTOR;
        PEXC_ST_VECTOR: state_q <= PEXC_ST_IDLE;
        default:        state_q <= PEXC_ST_IDLE;
      endcase
    end
  end

  // ====================================================
  // status word and banks
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      status_q <= `PEXC_SW_RESET;
      for (int i = 0; i < 6; i++) begin
        saved_q[i] <= 32'h0000_0000;
        lr_q[i]    <= 32'h0000_0000;
        sp_q[i]    <= 32'h0000_0000;
      end
    end else begin
      status_q <= status_d;
      if (state_q == PEXC_ST_ENTRY) begin
        saved_q[hidx_q] <= status_q;
        lr_q[hidx_q]    <= ent_pc_q - `PEXC_LINK_OFS;
      end else begin
        if (wr_saved) saved_q[cur_idx] <= be_merge(cur_saved, avs_writedata, avs_byteenable);
        if (wr_link)  lr_q[cur_idx] <= be_merge(lr_q[cur_idx], avs_writedata, avs_byteenable);
        if (wr_stack) sp_q[cur_idx] <= be_merge(sp_q[cur_idx], avs_writedata, avs_byteenable);
      end
    end
  end

  // ====================================================
  // pc load, last vector and bus read data
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pc_load_q <= 1'b0;
      pc_addr_q <= 32'h0000_0000;
      lastvec_q <= 32'h0000_0000;
      ack_q     <= 1'b0;
      rdata_q   <= 32'h0000_0000;
    end else begin
      pc_load_q <= (state_q == PEXC_ST_ENTRY) | ret_go;
      if (state_q == PEXC_ST_ENTRY) begin
        pc_addr_q <= cause_vec(cause_q);
        lastvec_q <= cause_vec(cause_q);
      end else if (ret_go) begin
        pc_addr_q <= ret_pc;
      end
      ack_q <= bus_acc;
      if (bus_acc) rdata_q <= rd_mux;
    end
  end

  assign avs_readdata    = rdata_q;
  assign pc_load         = pc_load_q;
  assign pc_load_addr    = pc_addr_q;
  assign cur_status_word = status_q;
  assign bank_sel        = cur_idx;
  assign fiq_bank_sel    = (cur_idx == 3'h1);
  assign entry_busy      = ~idle;

  // ====================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  reset_first_a: assert property (reset_p_q && idle |=> cause_q == PEXC_C_RESET &&
                                  state_q == PEXC_ST_ENTRY)
    else $error("reset exception not taken first");
  prio_pick_a: assert property (take |=> state_q == PEXC_ST_ENTRY && cause_q == $past(win))
    else $error("arbitration winner not entered");
  vec_map_a: assert property (state_q == PEXC_ST_ENTRY |=> pc_load && pc_load_addr <
                              `PEXC_VEC_BYTES && pc_load_addr != `PEXC_VEC_RSVD &&
                              pc_load_addr == cause_vec(cause_q))
    else $error("vector outside table or wrong");
  dabt_fiq_a: assert property ((state_q == PEXC_ST_VECTOR && cause_q == PEXC_C_DABT) ##1
                               (fiq_act && !reset_p_q && !pend_q[0])
                               |=> state_q == PEXC_ST_ENTRY && cause_q == PEXC_C_FIQ)
    else $error("fast interrupt not entered after data abort");
  saved_copy_a: assert property (state_q == PEXC_ST_ENTRY |=> saved_q[hidx_q] ==
                                 $past(status_q))
    else $error("status word not saved");
  mode_switch_a: assert property (state_q == PEXC_ST_ENTRY |=> bank_sel == hidx_q)
    else $error("handling mode not selected");
  mask_set_a: assert property (state_q == PEXC_ST_ENTRY |=> status_q[`PEXC_SW_I] &&
                               status_q[`PEXC_SW_F] == ($past(status_q[`PEXC_SW_F]) ||
                               cause_q == PEXC_C_FIQ))
    else $error("interrupt masks wrong on entry");
  link_value_a: assert property (state_q == PEXC_ST_ENTRY |=> lr_q[hidx_q] ==
                                 ent_pc_q - `PEXC_LINK_OFS)
    else $error("link register not pc minus 4");
  ret_restore_a: assert property (ret_go && priv |=> pc_load && status_q == $past(cur_saved) &&
                                  pc_load_addr == $past(ret_pc))
    else $error("return did not restore status");
  trap_excl_a: assert property (!(pend_q[3] && pend_q[2] && $past(swi_req && undef_req)))
    else $error("trap and illegal opcode both pending");
  irq_sample_a: assert property (take && win == PEXC_C_IRQ |-> int_win && !irq_s_q &&
                                 !status_q[`PEXC_SW_I])
    else $error("interrupt taken outside sample point");
  entry_atomic_a: assert property (state_q == PEXC_ST_ENTRY |=> state_q == PEXC_ST_VECTOR
                                   ##1 idle && (win == PEXC_C_NONE || take && !bus_acc))
    else $error("entry sequence not atomic");

  dabt_fiq_c: cover property (cause_q == PEXC_C_DABT ##2 state_q == PEXC_ST_ENTRY &&
                              cause_q == PEXC_C_FIQ);
  irq_entry_c: cover property (take && win == PEXC_C_IRQ);
  swi_entry_c: cover property (take && win == PEXC_C_SWI);
  ret_priv_c: cover property (ret_go && priv);

endmodule
`default_nettype wire

// *** tb.sv ***
// self-checking bench of the exception entry and return unit
// assumes pexc_defs.svh on the include path and the far side model beside it
`timescale 1ns/1ps
`default_nettype none
`include "pexc_defs.svh"

module tb;
  import pexc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq_n_pin, fiq_n_pin, pabt_req, dabt_req;
  logic        instr_done = 1'b0;
  logic        undef_req = 1'b0;
  logic        swi_req = 1'b0;
  logic [31:0] fetch_pc = 32'h0000_1000;
  logic        ret_dp_req = 1'b0;
  logic        ret_ldm_req = 1'b0;
  logic [31:0] ret_pc = 32'h0;
  logic        ret_ack, pc_load, fiq_bank_sel, entry_busy;
  logic [31:0] pc_load_addr, cur_status_word;
  pexc_bank_t  bank_sel;
  int          checked = 0;
  int          num_errors = 0;
  logic [31:0] vec [6] = '{`PEXC_VEC_SWI, `PEXC_VEC_UNDEF, `PEXC_VEC_PABT,
                           `PEXC_VEC_DABT, `PEXC_VEC_IRQ, `PEXC_VEC_FIQ};
  logic [31:0] sw [6] = '{32'h83, 32'h85, 32'h84, 32'h84, 32'h82, 32'hC1};

  always #20 clk_sys = ~clk_sys;

  pexc_unit i_dut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_n_pin(irq_n_pin), .fiq_n_pin(fiq_n_pin),
    .instr_done(instr_done), .undef_req(undef_req), .swi_req(swi_req),
    .pabt_req(pabt_req), .dabt_req(dabt_req), .fetch_pc(fetch_pc),
    .ret_dp_req(ret_dp_req), .ret_ldm_req(ret_ldm_req), .ret_pc(ret_pc),
    .ret_ack(ret_ack), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
    .cur_status_word(cur_status_word), .bank_sel(bank_sel),
    .fiq_bank_sel(fiq_bank_sel), .entry_busy(entry_busy));

  pexc_mmu_model i_mmu (.clk_sys(clk_sys), .pabt_req(pabt_req), .dabt_req(dabt_req),
    .irq_n_pin(irq_n_pin), .fiq_n_pin(fiq_n_pin));

  // ====================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address    <= a;
    avs_writedata  <= wd;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    if (n >= 200) num_errors++;
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, 4'hF, d);
    check(d, exp);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] d;
    bus(1'b1, a, wd, be, d);
  endtask

  task automatic wait_load(input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pc_load !== 1'b1 && n < 40);
    check(32'(pc_load), 32'h1);
    check(pc_load_addr, exp);
  endtask

  task automatic pulse_core(input logic u, input logic s, input logic d, input logic [31:0] pc);
    @(posedge clk_sys);
    undef_req  <= u;
    swi_req    <= s;
    instr_done <= d;
    fetch_pc   <= pc;
    @(posedge clk_sys);
    undef_req  <= 1'b0;
    swi_req    <= 1'b0;
    instr_done <= 1'b0;
  endtask

  // return request held until ret_ack is sampled high
  task automatic ret(input logic ldm, input logic [31:0] pc);
    int n;
    n = 0;
    @(posedge clk_sys);
    ret_dp_req  <= ~ldm;
    ret_ldm_req <= ldm;
    ret_pc      <= pc;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ret_ack !== 1'b1 && n < 40);
    check(32'(ret_ack), 32'h1);
    ret_dp_req  <= 1'b0;
    ret_ldm_req <= 1'b0;
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ====================================================
  // watchdog, far above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    final_report;
  end

  // ====================================================
  // tests
  initial begin
    logic [31:0] pc;
    int          n;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    wait_load(`PEXC_VEC_RESET);
    check(32'(entry_busy), 32'h1);
    check(cur_status_word, 32'h0000_00C3);
    check(32'(bank_sel), 32'h3);
    rd_chk(`PEXC_REG_LINK, 32'h0000_0FFC);
    rd_chk(`PEXC_REG_SAVED, `PEXC_SW_RESET);
    $display("test reset entry done");
    // only byte 0 written: user mode, masks clear
    wr(`PEXC_REG_STATUS, 32'hFFFF_FF00, 4'h1);
    rd_chk(`PEXC_REG_STATUS, 32'h0);
    for (int k = 0; k < 6; k++) begin
      pc = 32'h100 * (k + 1);
      if (k >= 4) begin
        i_mmu.pins(k == 4, k == 5);
        repeat (4) @(posedge clk_sys);
        check(32'(entry_busy), 32'h0);
      end
      pulse_core(k == 1, k == 0, k >= 4, pc);
      if (k == 2 || k == 3) i_mmu.raise(k == 3, k == 2);
      wait_load(vec[k]);
      check(cur_status_word, sw[k]);
      check(32'(bank_sel), 32'(sw[k][2:0]));
      check(32'(fiq_bank_sel), 32'(k == 5));
      i_mmu.pins(1'b0, 1'b0);
      rd_chk(`PEXC_REG_LINK, pc - 32'h4);
      rd_chk(`PEXC_REG_SAVED, 32'h0);
      rd_chk(`PEXC_REG_LASTVEC, vec[k]);
      ret(k[0], pc + 32'h4000);
      wait_load(pc + 32'h4000);
      check(cur_status_word, 32'h0);
    end
    $display("test single causes done");
    // data abort and fetch abort together while the fast pin is low
    i_mmu.pins(1'b0, 1'b1);
    repeat (3) @(posedge clk_sys);
    i_mmu.raise(1'b1, 1'b1);
    wait_load(`PEXC_VEC_DABT);
    wait_load(`PEXC_VEC_FIQ);
    wait_load(`PEXC_VEC_PABT);
    check(cur_status_word, 32'hC4);
    i_mmu.pins(1'b0, 1'b0);
    rd_chk(`PEXC_REG_SAVED, 32'hC1);
    wr(`PEXC_REG_STATUS, 32'h0, 4'hF);
    $display("test priority done");
    // both decodings flagged at once: only one entry follows
    pulse_core(1'b1, 1'b1, 1'b0, 32'h0000_3000);
    wait_load(`PEXC_VEC_UNDEF);
    n = 0;
    repeat (12) begin
      @(posedge clk_sys);
      if (pc_load === 1'b1) n++;
    end
    check(n, 0);
    check(32'(entry_busy), 32'h0);
    wr(`PEXC_REG_LASTVEC, 32'hFFFF_FFFF, 4'hF);
    rd_chk(`PEXC_REG_LASTVEC, `PEXC_VEC_UNDEF);
    rd_chk(5'h18, 32'h0);
    $display("test exclusive decode done");
    final_report;
  end
endmodule

`default_nettype wire
